// File: hw/vsltg_map.vh
// Constants for the video sync line timing generator.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef VSLTG_MAP_VH
`define VSLTG_MAP_VH

// ********************************************
// Indirect register indices (pointer values)
// ********************************************
`define VSLTG_NUM_VAL     11
`define VSLTG_IDX_LSYNC   8'h00
`define VSLTG_IDX_BLACK   8'h02
`define VSLTG_IDX_DCRST   8'h04
`define VSLTG_IDX_PARITY  8'h06
`define VSLTG_IDX_BLANK   8'h08
`define VSLTG_IDX_LINELEN 8'h14
`define VSLTG_IDX_VSAMPLE 8'h16
`define VSLTG_IDX_MODE    8'h17

// ********************************************
// Timing value entries (low byte at 2n, high at 2n+1)
// ********************************************
`define VSLTG_ENT_BLANK_START 8
`define VSLTG_ENT_BLANK_STOP  9
`define VSLTG_ENT_LINELEN     10
`define VSLTG_NUM_WIN         4
`define VSLTG_WIN_PARITY      3

// ********************************************
// Mode register fields
// ********************************************
`define VSLTG_MODE_LS_DRIVE   0
`define VSLTG_MODE_LS_POL     1
`define VSLTG_MODE_BLACK_POL  2
`define VSLTG_MODE_DCRST_POL  3
`define VSLTG_MODE_NONINT     4
`define VSLTG_MODE_PAR_POL    5
`define VSLTG_MODE_CAP_ARM    6
`define VSLTG_MODE_ACTIVE     7

// ********************************************
// Widths and reset values
// ********************************************
`define VSLTG_VAL_W       12
`define VSLTG_HI_MASK     8'h0f
`define VSLTG_RST_VAL     12'h000
`define VSLTG_RST_BYTE    8'h00
`define VSLTG_RST_PTR     8'h00
`endif

// File: hw/vsltg_top.v
// Line timing generator: counters, windows, sync outputs, host port.
// Assumes clk_sys_i is the pixel clock and all inputs are synchronous.
//
// Function
// - Parity gate window from start/stop counts
// - Parity high or low by start/stop order
// - Equal parity start/stop gives constant zero
// - Timing code n means n plus one
// - High byte bits 7..4 dropped, read zero
// - Value updates only on high byte write
// - High nibble forms bits 11..8
// - Noise gate closes at start, opens stop
// - Equal noise gate values keep gate open
// - Pixel count per line limited by length
// - Line sync clocked out, input passes through
// - Frame sync low during vertical interval lines
// - Composite sync passed combinationally
// - Black ref and restore with polarity
// - Noninterlaced parity constant; edges at frame sync
// - Phase compare high lags, low leads
// - Active frame one frame after trigger
// - Write on strobe rise, read drives bus
// - Select 0 pointer, 1 selected register
// - Frame sync sampled at 8-bit count
`timescale 1ns/100ps
`include "vsltg_map.vh"
`default_nettype none

module vsltg_top (
  input  wire       clk_sys_i,            // Pixel clock
  input  wire       arst_n_i,             // Async reset, active low
  input  wire       sync_raw_n_i,         // Detected composite sync, low in sync
  input  wire       line_sync_i,          // Line sync pin, input side
  output wire       line_sync_o,          // Line sync pin, output side
  output wire       line_sync_oe_n_o,     // Line sync drive, low drives
  output wire       composite_sync_n_o,   // Composite sync out
  output wire       frame_sync_n_o,       // Vertical sync out
  output wire       interlace_parity_o,   // Field parity out
  output wire       black_ref_strobe_o,   // Black reference strobe
  output wire       dc_restore_pulse_o,   // DC restore pulse
  output wire       active_frame_o,       // Capture frame window
  output wire       phase_compare_o,      // Phase comparator level
  output wire       phase_compare_oe_n_o, // Phase comparator drive, low drives
  input  wire       reg_select_i,         // 0 pointer, 1 data
  input  wire       read_strobe_n_i,      // Read strobe, active low
  input  wire       write_strobe_n_i,     // Write strobe, active low
  input  wire [7:0] host_data_bus_i,      // Host bus in
  output wire [7:0] host_data_bus_o,      // Host bus out
  output wire       host_data_bus_oe_n_o  // Host bus drive, low drives
);

  // ********************************************
  // Declarations
  // ********************************************
  reg  [7:0]  ptr_q;          // Address pointer
  reg  [7:0]  wdata_q;        // Data held while write strobe low
  reg         wsel_q;         // Select held while write strobe low
  reg         wr_n_prev_q;    // Write strobe last cycle
  reg  [7:0]  rdata_q;        // Read data flop
  reg  [7:0]  rdata_d;        // Read data next
  reg  [7:0]  vsample_q;      // Frame sync sample count
  reg  [6:0]  mode_q;         // Mode bits
  reg  [11:0] cnt_q;          // Pixel count since accepted edge
  reg         run_q;          // Counter started
  reg         sync_prev_n_q;  // Composite sync last cycle
  reg         gate_open_q;    // Noise gate state
  reg         fsync_n_q;      // Frame sync flop
  reg         parity_q;       // Parity flop
  reg         active_q;       // Active frame flop
  reg         field_prev_q;   // Parity last cycle
  wire        trig;           // Frame trigger for the active window
  wire        edge_cap_start; // Armed trigger opens a frame
  reg  [3:0]  win_q;          // Raw window states
  reg  [2:0]  out_q;          // Line sync, black ref, restore outputs
  wire [11:0] val    [0:`VSLTG_NUM_VAL-1]; // Working values
  wire [7:0]  lo_byte[0:`VSLTG_NUM_VAL-1]; // Held low bytes
  wire        wr_rise;        // Write strobe rising edge
  wire        wr_data;        // Committed data write
  wire        edge_ok;        // Accepted sync falling edge
  wire        fsync_fall;     // Frame sync falling this cycle
  wire        gen_sync;       // Line sync seen by comparator
  wire        rec_sync;       // Recovered sync, high active
  wire [11:0] blank_start;    // Noise gate start
  wire [11:0] blank_stop;     // Noise gate stop
  wire [11:0] line_len;       // Line length code
  wire [11:0] fsync_pt;       // Frame sync sample count widened
  wire        fsync_d;        // Frame sync next value
  wire        parity_sel;     // Parity to load at frame sync fall

  // ********************************************
  // Host strobe handling
  // ********************************************
  // Commit happens on the sampled rising edge of the write strobe
  assign wr_rise = ~wr_n_prev_q & write_strobe_n_i;
  assign wr_data = wr_rise & wsel_q;

  // Capture bus and select while strobe is low
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdata_q     <= `VSLTG_RST_BYTE;
      wsel_q      <= 1'b0;
      wr_n_prev_q <= 1'b1;
    end else begin
      wr_n_prev_q <= write_strobe_n_i;
      if (!write_strobe_n_i) begin
        wdata_q <= host_data_bus_i;
        wsel_q  <= reg_select_i;
      end
    end
  end

  // Pointer, sample count and mode registers
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_q     <= `VSLTG_RST_PTR;
      vsample_q <= `VSLTG_RST_BYTE;
      mode_q    <= 7'h00;
    end else begin
      // Select 0 writes the pointer
      if (wr_rise && !wsel_q) begin
        ptr_q <= wdata_q;
      end
      if (wr_data && ptr_q == `VSLTG_IDX_VSAMPLE) begin
        vsample_q <= wdata_q;
      end
      if (wr_data && ptr_q == `VSLTG_IDX_MODE) begin
        mode_q <= wdata_q[6:0];
      end else if (edge_cap_start) begin
        // Hardware consumes the arm bit when the frame starts
        mode_q[`VSLTG_MODE_CAP_ARM] <= 1'b0;
      end
    end
  end

  // ********************************************
  // Timing value storage, one entry per value
  // ********************************************
  genvar gi;
  generate
    for (gi = 0; gi < `VSLTG_NUM_VAL; gi = gi + 1) begin : g_val
      reg [7:0]  lo_q;  // Low byte holding register
      reg [11:0] val_q; // Combined working value
      always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          lo_q  <= `VSLTG_RST_BYTE;
          val_q <= `VSLTG_RST_VAL;
        end else if (wr_data && ptr_q == gi * 2) begin
          // Low byte held until the high byte arrives
          lo_q <= wdata_q;
        end else if (wr_data && ptr_q == gi * 2 + 1) begin
          // High nibble on top, upper bits dropped
          val_q <= {wdata_q[3:0], lo_q};
        end
      end
      assign val[gi]     = val_q;
      assign lo_byte[gi] = lo_q;
    end
  endgenerate

  // ********************************************
  // Read path
  // ********************************************
  // Select the byte that the pointer names
  always @* begin : p_rd
    integer k;
    k       = 0;
    rdata_d = `VSLTG_RST_BYTE;
    if (!reg_select_i) begin
      rdata_d = ptr_q;
    end else begin
      for (k = 0; k < `VSLTG_NUM_VAL; k = k + 1) begin
        if (ptr_q == k * 2) begin
          rdata_d = lo_byte[k];
        end
        if (ptr_q == k * 2 + 1) begin
          // Upper nibble reads zero
          rdata_d = {4'h0, val[k][11:8]} & `VSLTG_HI_MASK;
        end
      end
      if (ptr_q == `VSLTG_IDX_VSAMPLE) begin
        rdata_d = vsample_q;
      end
      if (ptr_q == `VSLTG_IDX_MODE) begin
        rdata_d = {active_q, mode_q};
      end
    end
  end

  // Read data flop
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= `VSLTG_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Drive only while read strobe low
  assign host_data_bus_o      = rdata_q;
  assign host_data_bus_oe_n_o = read_strobe_n_i;

  // ********************************************
  // Line counter and noise gate
  // ********************************************
  assign blank_start = val[`VSLTG_ENT_BLANK_START];
  assign blank_stop  = val[`VSLTG_ENT_BLANK_STOP];
  assign line_len    = val[`VSLTG_ENT_LINELEN];
  // Only edges seen with the gate open restart the line
  assign edge_ok     = sync_prev_n_q & ~sync_raw_n_i & gate_open_q;

  // Count from zero, code n matches n+1 clocks after edge
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q         <= 12'h000;
      run_q         <= 1'b0;
      sync_prev_n_q <= 1'b1;
    end else begin
      sync_prev_n_q <= sync_raw_n_i;
      if (edge_ok) begin
        cnt_q <= 12'h000;
        run_q <= 1'b1;
      end else if (run_q && cnt_q != line_len) begin
        // Stop at the programmed line length
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

  // Noise gate closes at start, opens at stop
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_open_q <= 1'b1;
    end else if (blank_start == blank_stop) begin
      gate_open_q <= 1'b1;
    end else if (run_q && !edge_ok && cnt_q == blank_start) begin
      gate_open_q <= 1'b0;
    end else if (run_q && !edge_ok && cnt_q == blank_stop) begin
      gate_open_q <= 1'b1;
    end
  end

  // ********************************************
  // Programmable windows
  // ********************************************
  generate
    for (gi = 0; gi < `VSLTG_NUM_WIN; gi = gi + 1) begin : g_win
      // Set at start count, clear at stop, zero when equal
      always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          win_q[gi] <= 1'b0;
        end else if (val[gi * 2] == val[gi * 2 + 1]) begin
          win_q[gi] <= 1'b0;
        end else if (run_q && !edge_ok && cnt_q == val[gi * 2]) begin
          win_q[gi] <= 1'b1;
        end else if (run_q && !edge_ok && cnt_q == val[gi * 2 + 1]) begin
          win_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Outputs with polarity, changing after the clock edge
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= 3'h0;
    end else begin
      out_q[0] <= win_q[0] ^ mode_q[`VSLTG_MODE_LS_POL];
      out_q[1] <= win_q[1] ^ mode_q[`VSLTG_MODE_BLACK_POL];
      out_q[2] <= win_q[2] ^ mode_q[`VSLTG_MODE_DCRST_POL];
    end
  end

  assign line_sync_o        = out_q[0];
  assign line_sync_oe_n_o   = ~mode_q[`VSLTG_MODE_LS_DRIVE];
  assign black_ref_strobe_o = out_q[1];
  assign dc_restore_pulse_o = out_q[2];

  // ********************************************
  // Frame sync, parity and active frame
  // ********************************************
  assign fsync_pt   = {4'h0, vsample_q};
  // Sample composite sync once per line at the programmed count
  assign fsync_d    = (run_q && !edge_ok && cnt_q == fsync_pt) ? sync_raw_n_i : fsync_n_q;
  assign fsync_fall = fsync_n_q & ~fsync_d;
  // Window level at the fall picks the field when interlaced
  assign parity_sel = mode_q[`VSLTG_MODE_NONINT] ? mode_q[`VSLTG_MODE_PAR_POL]
                                                 : win_q[`VSLTG_WIN_PARITY];

  // Frame sync low on vertical interval lines
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fsync_n_q <= 1'b1;
    end else begin
      fsync_n_q <= fsync_d;
    end
  end

  // Parity only moves at frame sync falling edge
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      parity_q     <= 1'b0;
      field_prev_q <= 1'b0;
    end else begin
      field_prev_q <= parity_q;
      if (fsync_fall) begin
        parity_q <= parity_sel;
      end
    end
  end

  // Trigger: parity rise if interlaced, frame sync fall otherwise
  assign trig           = mode_q[`VSLTG_MODE_NONINT] ? fsync_fall : (parity_q & ~field_prev_q);
  assign edge_cap_start = trig & ~active_q & mode_q[`VSLTG_MODE_CAP_ARM];

  // One frame of active output per arm
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_q <= 1'b0;
    end else if (trig) begin
      if (active_q) begin
        active_q <= 1'b0;
      end else if (mode_q[`VSLTG_MODE_CAP_ARM]) begin
        active_q <= 1'b1;
      end
    end
  end

  assign frame_sync_n_o     = fsync_n_q;
  assign interlace_parity_o = parity_q;
  assign active_frame_o     = active_q;

  // ********************************************
  // Composite sync and phase comparator
  // ********************************************
  // Passed straight through
  assign composite_sync_n_o = sync_raw_n_i;

  // Pin input reaches comparator without pipeline
  assign gen_sync = mode_q[`VSLTG_MODE_LS_DRIVE] ? win_q[0] : line_sync_i;
  assign rec_sync = ~sync_raw_n_i;

  // High when generated lags, low when it leads, else released
  assign phase_compare_o      = rec_sync & ~gen_sync;
  assign phase_compare_oe_n_o = ~(rec_sync ^ gen_sync);

endmodule

`default_nettype wire

// File: hw/dummy_unused_marker.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: verif/vsltg_sync_src.sv
// Sync source model: line pulses, broad vertical pulses, optional mid-line pulse.
// Assumes it shares the pixel clock and reset with the design.
`timescale 1ns/100ps
`default_nettype none
module vsltg_sync_src #(
  parameter int LINE = 64 // Pixels per line
) (
  input  wire logic clk_sys_i,    // Pixel clock
  input  wire logic arst_n_i,     // Async reset, active low
  input  wire logic vert_i,       // Broad pulses in lines 0 and 1
  input  wire logic eq_i,         // Extra pulse at mid-line
  output var  logic sync_raw_n_o, // Composite sync, low in sync
  output var  logic line_sync_o   // Recovered line sync to the pin
);
  logic [6:0] pix_q; // Pixel in line
  logic [2:0] ln_q;  // Line in frame
  // ************************************
  // Counters
  // ************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pix_q <= 7'h00;
      ln_q  <= 3'h0;
    end else if (pix_q == 7'(LINE - 1)) begin
      pix_q <= 7'h00;
      ln_q  <= ln_q + 3'h1;
    end else begin
      pix_q <= pix_q + 7'h01;
    end
  end
  // Sync level from the pixel position
  always_comb begin
    sync_raw_n_o = !(pix_q < 7'h04 || (vert_i && ln_q < 3'h2 && pix_q < 7'h38)
                   || (eq_i && pix_q >= 7'h20 && pix_q < 7'h24));
    line_sync_o  = pix_q >= 7'h02 && pix_q < 7'h06;
  end
endmodule
`default_nettype wire

// File: verif/vsltg_chk_sva.sv
// Port checker for the line timing generator.
// Assumes the top module's ports only and a single pixel clock.
`timescale 1ns/100ps
`default_nettype none
module vsltg_chk (
  input wire logic       clk_sys_i,
  input wire logic       arst_n_i,
  input wire logic       sync_raw_n_i,
  input wire logic       line_sync_i,
  input wire logic       line_sync_o,
  input wire logic       line_sync_oe_n_o,
  input wire logic       composite_sync_n_o,
  input wire logic       frame_sync_n_o,
  input wire logic       interlace_parity_o,
  input wire logic       black_ref_strobe_o,
  input wire logic       dc_restore_pulse_o,
  input wire logic       active_frame_o,
  input wire logic       phase_compare_o,
  input wire logic       phase_compare_oe_n_o,
  input wire logic       reg_select_i,
  input wire logic       read_strobe_n_i,
  input wire logic       write_strobe_n_i,
  input wire logic [7:0] host_data_bus_i,
  input wire logic [7:0] host_data_bus_o,
  input wire logic       host_data_bus_oe_n_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [3:0] age_q;  // Cycles since any frame trigger
  logic [3:0] fage_q; // Cycles since frame sync fell
  logic [7:0] ptr_q;  // Shadow of the pointer
  logic [7:0] wdat_q; // Byte held during a write
  logic       wsel_q; // Select held during a write
  // ************************************
  // Helper state
  // ************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_q  <= 4'hf;
      fage_q <= 4'hf;
      ptr_q  <= 8'h00;
      wdat_q <= 8'h00;
      wsel_q <= 1'b0;
    end else begin
      age_q  <= ($fell(frame_sync_n_o) || $rose(interlace_parity_o)) ? 4'h0 :
                (age_q == 4'hf) ? age_q : age_q + 4'h1;
      fage_q <= $fell(frame_sync_n_o) ? 4'h0 : (fage_q == 4'hf) ? fage_q : fage_q + 4'h1;
      if (!write_strobe_n_i) begin
        wdat_q <= host_data_bus_i;
        wsel_q <= reg_select_i;
      end else if (!$past(write_strobe_n_i) && !wsel_q) begin
        ptr_q <= wdat_q;
      end
    end
  end
  sequence s_rd_hold;
    (!read_strobe_n_i && write_strobe_n_i && $stable(reg_select_i))[*3];
  endsequence
  sequence s_trig_near;
    age_q <= 4'h3 || $fell(frame_sync_n_o) || $rose(interlace_parity_o);
  endsequence
  a_composite_sync_n_comb: assert property (composite_sync_n_o == sync_raw_n_i)
    else $error("composite sync out differs from detected sync");
  a_bus_drive_rd: assert property (host_data_bus_oe_n_o == read_strobe_n_i)
    else $error("host bus drive does not follow read strobe");
  a_hi_nibble_zero: assert property (
    s_rd_hold ##0 (reg_select_i && ptr_q[0] && ptr_q < 8'h16) |-> host_data_bus_o[7:4] == 4'h0)
    else $error("high byte read shows upper bits set");
  a_rd_data_hold: assert property (s_rd_hold |-> $stable(host_data_bus_o))
    else $error("read data moved while selection held");
  a_parity_at_frame: assert property (
    $changed(interlace_parity_o) |-> fage_q <= 4'h2 || $fell(frame_sync_n_o))
    else $error("parity changed away from a frame sync fall");
  a_active_rise: assert property ($rose(active_frame_o) |-> s_trig_near)
    else $error("active frame rose without a trigger");
  a_active_fall: assert property ($fell(active_frame_o) |-> s_trig_near)
    else $error("active frame fell without a trigger");
  a_ls_drive_wr: assert property (
    $changed(line_sync_oe_n_o) |-> !$past(write_strobe_n_i) || !$past(write_strobe_n_i, 2))
    else $error("line sync drive changed without a write");
  a_phase_lag_dir: assert property (
    (!phase_compare_oe_n_o && line_sync_oe_n_o) |-> phase_compare_o == !line_sync_i)
    else $error("phase compare level disagrees with line sync order");
endmodule
bind vsltg_top vsltg_chk vsltg_chk_i (
  .clk_sys_i, .arst_n_i, .sync_raw_n_i, .line_sync_i, .line_sync_o, .line_sync_oe_n_o,
  .composite_sync_n_o, .frame_sync_n_o, .interlace_parity_o, .black_ref_strobe_o,
  .dc_restore_pulse_o, .active_frame_o, .phase_compare_o, .phase_compare_oe_n_o,
  .reg_select_i, .read_strobe_n_i, .write_strobe_n_i, .host_data_bus_i, .host_data_bus_o,
  .host_data_bus_oe_n_o
);
`default_nettype wire

// File: verif/vsltg_top_tb.sv
// Self-checking bench for the line timing generator.
// Assumes design, sync source model and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "vsltg_map.vh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module vsltg_top_tb;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, reg_select_i = 1'b0;
  logic read_strobe_n_i = 1'b1, write_strobe_n_i = 1'b1, vert_i = 1'b0, eq_i = 1'b0;
  logic [7:0] hdrv = 8'h00; // Host drive value
  wire sync_raw_n_i, src_ls, line_sync_i, line_sync_o, line_sync_oe_n_o, composite_sync_n_o;
  wire frame_sync_n_o, interlace_parity_o, black_ref_strobe_o, dc_restore_pulse_o;
  wire active_frame_o, phase_compare_o, phase_compare_oe_n_o, host_data_bus_oe_n_o;
  wire [7:0] host_data_bus_i, host_data_bus_o;
  int bad_count = 0, check_count = 0;
  // Shared pins resolved from both drivers
  assign line_sync_i = line_sync_oe_n_o ? src_ls : line_sync_o;
  assign host_data_bus_i = host_data_bus_oe_n_o ? hdrv : host_data_bus_o;
  always #20 clk_sys_i = ~clk_sys_i;
  vsltg_top vsltg_top_i (.clk_sys_i, .arst_n_i, .sync_raw_n_i, .line_sync_i, .line_sync_o,
    .line_sync_oe_n_o, .composite_sync_n_o, .frame_sync_n_o, .interlace_parity_o,
    .black_ref_strobe_o, .dc_restore_pulse_o, .active_frame_o, .phase_compare_o,
    .phase_compare_oe_n_o, .reg_select_i, .read_strobe_n_i, .write_strobe_n_i,
    .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_n_o);
  vsltg_sync_src vsltg_sync_src_i (.clk_sys_i, .arst_n_i, .vert_i, .eq_i,
    .sync_raw_n_o(sync_raw_n_i), .line_sync_o(src_ls));
  // ************************************
  // Host access tasks
  // ************************************
  task automatic reg_wr(input logic s, input logic [7:0] d);
    @(posedge clk_sys_i);
    write_strobe_n_i <= 1'b0;
    reg_select_i     <= s;
    hdrv             <= d;
    @(posedge clk_sys_i);
    write_strobe_n_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    reg_wr(1'b0, idx);
    @(posedge clk_sys_i);
    read_strobe_n_i <= 1'b0; // Never overlaps a write
    reg_select_i    <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 d = host_data_bus_o;
    @(posedge clk_sys_i);
    read_strobe_n_i <= 1'b1;
  endtask
  task automatic wval(input int e, input logic [11:0] v);
    reg_wr(1'b0, 8'(2 * e));
    reg_wr(1'b1, v[7:0]);
    reg_wr(1'b0, 8'(2 * e + 1));
    reg_wr(1'b1, {4'hf, v[11:8]}); // Junk upper bits
  endtask
  task automatic wmode(input logic [7:0] m);
    reg_wr(1'b0, `VSLTG_IDX_MODE);
    reg_wr(1'b1, m);
  endtask
  function automatic logic outsel(input int k);
    case (k)
      0: return line_sync_o;
      1: return black_ref_strobe_o;
      default: return dc_restore_pulse_o;
    endcase
  endfunction
  // Edges from a main sync fall to leaving and regaining idle level
  task automatic meas(input int k, input logic lv, output int n1, output int n2);
    // First line settles the new setting, the second one is measured
    repeat (2) begin
      do @(negedge sync_raw_n_i); while (vsltg_sync_src_i.pix_q != 7'h00);
    end
    #1 n1 = 0;
    while (outsel(k) === lv && n1 < 70) begin
      @(posedge clk_sys_i);
      #1 n1++;
    end
    n2 = n1;
    while (outsel(k) !== lv && n2 < 70) begin
      @(posedge clk_sys_i);
      #1 n2++;
    end
  endtask
  task automatic wait_fs(input logic v);
    int n;
    #1 n = 0;
    while (frame_sync_n_o !== v && n < 2000) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_regs;
    logic [7:0] d;
    wval(6, 12'habc);
    reg_rd(8'h0c, d);
    `CHK("par_start_lo", 8'hbc, d)
    reg_rd(8'h0d, d);
    `CHK("par_start_hi", 8'h0a, d)
    reg_wr(1'b0, 8'h30);
    reg_wr(1'b1, 8'h55);
    reg_rd(8'h30, d);
    `CHK("unmapped", 8'h00, d)
    reg_wr(1'b0, `VSLTG_IDX_VSAMPLE);
    reg_wr(1'b1, 8'h10);
    reg_rd(`VSLTG_IDX_VSAMPLE, d);
    `CHK("vsample", 8'h10, d)
    $display("test regs done");
  endtask
  task automatic t_win;
    int n1, n2;
    wval(`VSLTG_ENT_LINELEN, 12'd62); // Line length first
    for (int k = 0; k < 3; k++) begin
      wval(2 * k, 12'(8 + k));
      wval(2 * k + 1, 12'(30 + k));
      for (int p = 0; p < 2; p++) begin
        wmode(8'(p * (2 << k)) | 8'h01);
        meas(k, 1'(p), n1, n2);
        `CHK("win_start", 8 + k + 3, n1)
        `CHK("win_stop", 30 + k + 3, n2)
      end
    end
    `CHK("ls_driven", 1'b0, line_sync_oe_n_o)
    wmode(8'h01);
    reg_wr(1'b0, 8'h04);
    reg_wr(1'b1, 8'd20);
    meas(1, 1'b0, n1, n2);
    `CHK("lone_low_held", 12, n1)
    reg_wr(1'b0, 8'h05);
    reg_wr(1'b1, 8'h00);
    meas(1, 1'b0, n1, n2);
    `CHK("high_commits", 23, n1)
    wval(`VSLTG_ENT_LINELEN, 12'd40);
    wval(2, 12'd50);
    wval(3, 12'd55);
    meas(1, 1'b0, n1, n2);
    `CHK("beyond_length", 70, n1)
    $display("test windows done");
  endtask
  task automatic t_gate;
    int n1, n2;
    wval(`VSLTG_ENT_LINELEN, 12'd62);
    wval(4, 12'd45);
    wval(5, 12'd50);
    wval(`VSLTG_ENT_BLANK_START, 12'd20); // Below half a line
    wval(`VSLTG_ENT_BLANK_STOP, 12'd40); // Beyond half a line
    eq_i <= 1'b1;
    meas(2, 1'b0, n1, n2);
    `CHK("gate_closed", 48, n1)
    wval(`VSLTG_ENT_BLANK_STOP, 12'd20);
    meas(2, 1'b0, n1, n2);
    `CHK("gate_open", 70, n1)
    eq_i <= 1'b0;
    $display("test noise gate done");
  endtask
  task automatic t_vert;
    logic [7:0] d;
    int n;
    vert_i <= 1'b1;
    wait_fs(1'b0); // Skip an interval that may have begun part way
    wait_fs(1'b1);
    wmode(8'h70);
    wait_fs(1'b0);
    n = 0;
    while (frame_sync_n_o === 1'b0 && n < 2000) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    `CHK("vsync_low_len", 128, n)
    `CHK("parity_nonint", 1'b1, interlace_parity_o)
    `CHK("active_set", 1'b1, active_frame_o)
    `CHK("ls_released", 1'b1, line_sync_oe_n_o)
    reg_rd(`VSLTG_IDX_MODE, d);
    `CHK("mode_rd", 8'hb0, d)
    wval(6, 12'd10);
    wval(7, 12'd10);
    wmode(8'h00);
    wait_fs(1'b0);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK("parity_equal", 1'b0, interlace_parity_o)
    wval(6, 12'd8); // Spacing of exactly half a line
    wval(7, 12'd40);
    wait_fs(1'b1);
    wait_fs(1'b0);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK("parity_start_low", 1'b1, interlace_parity_o)
    wval(6, 12'd40);
    wval(7, 12'd8);
    wait_fs(1'b1);
    wait_fs(1'b0);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK("parity_start_high", 1'b0, interlace_parity_o)
    wmode(8'h30);
    wait_fs(1'b1);
    wait_fs(1'b0);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK("parity_level", 1'b1, interlace_parity_o)
    `CHK("active_clear", 1'b0, active_frame_o)
    vert_i <= 1'b0;
    $display("test vertical done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_win();
    t_gate();
    t_vert();
    print_verdict();
  end
  // Watchdog
  initial begin
    #(40 * 40000);
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
